// ### rtl/led_bank_pkg.sv
// constants and field layout of the led driver register bank
// Function
// - address 0x00 is shutdown control; bit 0 selects shutdown; resets to zero
// - shutdown control bit 0 low means software shutdown; the block starts shut down
// - addresses 0x01..0x24 hold 8-bit duty values for channels 1..36, reset zero
// - writing zero to address 0x25 moves staged duty and control values to the outputs
// - addresses 0x26..0x49 hold per-channel enable and current scale, reset zero
// - address 0x4a holds one global enable control, reset zero
// - address 0x4b holds the common pwm frequency choice, reset zero
// - writing zero to address 0x4f returns every register to its default
// - duty and control writes stay staged until zero is written to the update address
// - zero written to soft reset restores defaults; same defaults after power-up
// - control bit 0 turns the led on; bits 2:1 scale current 1, 1/2, 1/3, 1/4
package led_bank_pkg;
  localparam int NUM_CH = 36;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'h00;
  localparam logic [7:0] ADDR_DUTY_FIRST = 8'h01;
  localparam logic [7:0] ADDR_DUTY_LAST = 8'h24;
  localparam logic [7:0] ADDR_APPLY = 8'h25;
  localparam logic [7:0] ADDR_CTRL_FIRST = 8'h26;
  localparam logic [7:0] ADDR_CTRL_LAST = 8'h49;
  localparam logic [7:0] ADDR_GLOBAL = 8'h4a;
  localparam logic [7:0] ADDR_FREQ = 8'h4b;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h4f;
  localparam logic [7:0] TRIGGER_VALUE = 8'h00;
  localparam int SHUTDOWN_BIT = 0;
  localparam int GLOBAL_BIT = 0;
  localparam int FREQ_BIT = 0;
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SCALE_LSB = 1;
  localparam int CTRL_SCALE_MSB = 2;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [4:0] SLAVE_ADDR_HIGH = 5'h0f;
  localparam logic [2:0] LAST_BIT = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_DEV_ACK = 3'b011,
    ST_REG = 3'b010,
    ST_REG_ACK = 3'b110,
    ST_DAT = 3'b111,
    ST_DAT_ACK = 3'b101
  } link_state_e;
endpackage

// ### rtl/led_driver_register_map.sv
// write-only register bank of the 36-channel led driver behind its two-wire serial slave
`timescale 1ns/1ps
module led_driver_register_map (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_select,
  output logic soft_shutdown_bit,
  output logic global_enable,
  output logic frequency_choice,
  output logic [led_bank_pkg::NUM_CH-1:0][7:0] channel_duty,
  output logic [led_bank_pkg::NUM_CH-1:0] channel_on,
  output logic [led_bank_pkg::NUM_CH-1:0][1:0] current_scale
);
  import led_bank_pkg::*;

  function automatic logic in_span(input logic [7:0] a, input logic [7:0] lo,
                                   input logic [7:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [5:0] chan_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] diff;
    diff = a - base;
    chan_index = diff[5:0];
  endfunction

  // two-flop synchronisers; stage one feeds only stage two
  logic scl_m, scl_s, scl_q;
  logic sda_m, sda_s, sda_q;
  logic [1:0] ad_m, ad_s;

  always_ff @(posedge mclk) begin
    scl_m <= scl_in;
    scl_s <= scl_m;
    scl_q <= scl_s;
    sda_m <= sda_in;
    sda_s <= sda_m;
    sda_q <= sda_s;
    ad_m <= addr_select;
    ad_s <= ad_m;
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_seen = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_seen = scl_s & scl_q & ~sda_q & sda_s;

  link_state_e state, next_state;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic byte_done;
  logic [7:0] pointer;
  logic ack_drive;

  wire [7:0] rx_byte = shreg;
  wire shift_state = (state == ST_DEV) || (state == ST_REG) || (state == ST_DAT);
  wire ack_state = (state == ST_DEV_ACK) || (state == ST_REG_ACK) || (state == ST_DAT_ACK);
  // the read/write bit must be zero; a read request is simply not acknowledged
  wire addr_match = (rx_byte[7:1] == {SLAVE_ADDR_HIGH, ad_s}) && !rx_byte[0];
  wire byte_end = shift_state && byte_done && scl_fall;
  wire ack_end = ack_state && scl_fall;
  wire data_write = byte_end && (state == ST_DAT);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_DEV: if (byte_end) next_state = addr_match ? ST_DEV_ACK : ST_IDLE;
      ST_DEV_ACK: if (ack_end) next_state = ST_REG;
      ST_REG: if (byte_end) next_state = ST_REG_ACK;
      ST_REG_ACK: if (ack_end) next_state = ST_DAT;
      ST_DAT: if (byte_end) next_state = ST_DAT_ACK;
      ST_DAT_ACK: if (ack_end) next_state = ST_DAT;
    endcase
    if (start_seen) next_state = ST_DEV;
    else if (stop_seen) next_state = ST_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      byte_done <= 1'b0;
      pointer <= 8'h00;
      ack_drive <= 1'b0;
    end else begin
      state <= next_state;
      if (start_seen || ack_end) begin
        bitcnt <= 3'h0;
        byte_done <= 1'b0;
      end else if (shift_state && scl_rise) begin
        shreg <= {shreg[6:0], sda_s};
        bitcnt <= bitcnt + 3'h1;
        byte_done <= (bitcnt == LAST_BIT);
      end
      if (byte_end && state == ST_REG) pointer <= rx_byte;
      else if (data_write) pointer <= pointer + 8'h01;
      // unlisted addresses are still acknowledged
      if (start_seen || stop_seen || ack_end) ack_drive <= 1'b0;
      else if (byte_end && (state != ST_DEV || addr_match)) ack_drive <= 1'b1;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = ack_drive;

  // register decode on the completed data byte
  wire hit_shutdown = data_write && (pointer == ADDR_SHUTDOWN);
  wire hit_duty = data_write && in_span(pointer, ADDR_DUTY_FIRST, ADDR_DUTY_LAST);
  wire hit_ctrl = data_write && in_span(pointer, ADDR_CTRL_FIRST, ADDR_CTRL_LAST);
  wire hit_global = data_write && (pointer == ADDR_GLOBAL);
  wire hit_freq = data_write && (pointer == ADDR_FREQ);
  // only an all-zero byte triggers; other values are ignored
  wire do_apply = data_write && (pointer == ADDR_APPLY) && (rx_byte == TRIGGER_VALUE);
  wire do_clear = data_write && (pointer == ADDR_SOFT_RESET) && (rx_byte == TRIGGER_VALUE);
  wire [5:0] duty_idx = chan_index(pointer, ADDR_DUTY_FIRST);
  wire [5:0] ctrl_idx = chan_index(pointer, ADDR_CTRL_FIRST);
  wire bank_clear = !rst_n || do_clear;

  logic [7:0] duty_stage [NUM_CH];
  logic [2:0] ctrl_stage [NUM_CH];
  logic [2:0] ctrl_live [NUM_CH];

  always_ff @(posedge mclk) begin
    if (bank_clear) begin
      soft_shutdown_bit <= FLAG_RESET;
      global_enable <= FLAG_RESET;
      frequency_choice <= FLAG_RESET;
    end else begin
      if (hit_shutdown) soft_shutdown_bit <= rx_byte[SHUTDOWN_BIT];
      if (hit_global) global_enable <= rx_byte[GLOBAL_BIT];
      if (hit_freq) frequency_choice <= rx_byte[FREQ_BIT];
    end
  end

  // one process owns every channel word, so each array keeps a single driver
  always_ff @(posedge mclk) begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (bank_clear) begin
        duty_stage[ch] <= DUTY_RESET;
        ctrl_stage[ch] <= CTRL_RESET;
        channel_duty[ch] <= DUTY_RESET;
        ctrl_live[ch] <= CTRL_RESET;
      end else begin
        if (hit_duty && duty_idx == 6'(ch)) duty_stage[ch] <= rx_byte;
        if (hit_ctrl && ctrl_idx == 6'(ch)) begin
          ctrl_stage[ch] <= rx_byte[CTRL_SCALE_MSB:0];
        end
        // staged values reach the outputs only on the update trigger
        if (do_apply) begin
          channel_duty[ch] <= duty_stage[ch];
          ctrl_live[ch] <= ctrl_stage[ch];
        end
      end
    end
  end

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    assign channel_on[ch] = ctrl_live[ch][CTRL_ON_BIT];
    assign current_scale[ch] = ctrl_live[ch][CTRL_SCALE_MSB:CTRL_SCALE_LSB];
  end

endmodule

// ### tb/led_bank_properties.sv
// port assertions for the led register bank
`timescale 1ns/1ps
module led_bank_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic soft_shutdown_bit,
  input wire logic [led_bank_pkg::NUM_CH-1:0][7:0] channel_duty,
  input wire logic [led_bank_pkg::NUM_CH-1:0] channel_on
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // outputs move only next to an acked byte, never in an scl high phase
  reset_clear_a: assert property ($rose(rst_n) |-> channel_duty == '0)
    else $error("duty not cleared");
  shut_reset_a: assert property ($rose(rst_n) |-> !soft_shutdown_bit)
    else $error("not shut down");
  duty_ack_a: assert property ($changed(channel_duty) |-> ##[0:3] sda_oe)
    else $error("duty off ack");
  on_ack_a: assert property ($changed(channel_on) |-> ##[0:3] sda_oe)
    else $error("enable off ack");
  shut_ack_a: assert property ($changed(soft_shutdown_bit) |-> ##[0:3] sda_oe)
    else $error("shutdown off ack");
  ack_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("ack in scl high");
  duty_low_a: assert property ($changed(channel_duty) |-> !scl_in)
    else $error("duty in scl high");
  on_low_a: assert property ($changed(channel_on) |-> !scl_in)
    else $error("enable in scl high");
endmodule
bind led_driver_register_map led_bank_properties led_bank_properties_inst (
  .mclk(mclk),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .sda_oe(sda_oe),
  .soft_shutdown_bit(soft_shutdown_bit),
  .channel_duty(channel_duty),
  .channel_on(channel_on)
);

// ### tb/i2c_host_model.sv
// two-wire host that only writes
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl = 1'b1,
  output logic sda = 1'b1
);
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // no read phase exists here; ninth pulse of each byte samples the ack
  task automatic frame(input logic [7:0] b[$], output int nacks);
    nacks = 0;
    sda <= 1'b0;
    hold(8);
    foreach (b[k]) for (int i = 8; i >= 0; i--) begin
      scl <= 1'b0;
      hold(5);
      sda <= (i == 0) ? 1'b1 : b[k][i-1];
      hold(5);
      scl <= 1'b1;
      hold(8);
      if (i == 0 && sda_line) nacks++;
    end
    scl <= 1'b0;
    hold(5);
    sda <= 1'b0;
    hold(5);
    scl <= 1'b1;
    hold(8);
    sda <= 1'b1;
    hold(8);
  endtask
endmodule

// ### tb/led_driver_register_map_bench.sv
// bench: host frames into the led register bank
`timescale 1ns/1ps
module led_driver_register_map_bench;
  import led_bank_pkg::*;
  localparam logic [7:0] DEV = {SLAVE_ADDR_HIGH, 2'b10, 1'b0};
  localparam logic [7:0] DEV_ALT = {SLAVE_ADDR_HIGH, 2'b01, 1'b0};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr_select = 2'b10;
  logic scl_in, host_sda, sda_out, sda_oe, soft_shutdown_bit, global_enable, frequency_choice;
  logic [NUM_CH-1:0][7:0] channel_duty;
  logic [NUM_CH-1:0] channel_on;
  logic [NUM_CH-1:0][1:0] current_scale;
  // open-drain line: the host side stands in for the pull-up
  wire logic sda_in = host_sda & !(sda_oe & !sda_out);
  wire logic [2:0] flags = {soft_shutdown_bit, global_enable, frequency_choice};
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int nacks;
  initial forever #4 mclk = ~mclk;
  led_driver_register_map led_driver_register_map_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .addr_select(addr_select),
    .soft_shutdown_bit(soft_shutdown_bit),
    .global_enable(global_enable),
    .frequency_choice(frequency_choice),
    .channel_duty(channel_duty),
    .channel_on(channel_on),
    .current_scale(current_scale)
  );
  i2c_host_model i2c_host_model_inst (
    .mclk(mclk),
    .sda_line(sda_in),
    .scl(scl_in),
    .sda(host_sda)
  );
  task automatic fail(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic test_done();
    $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] b[$], input int n);
    i2c_host_model_inst.frame(b, nacks);
    tests_run++;
    if (nacks != n) fail("ack count");
  endtask
  task automatic t_reset();
    tests_run++;
    if (channel_duty !== '0 || channel_on !== '0) fail("channels not reset");
    tests_run++;
    if (current_scale !== '0) fail("scale not reset");
    tests_run++;
    if (flags !== 3'b000) fail("flags not at default");
    tests_run++;
    if (sda_oe !== 1'b0 || sda_out !== 1'b0) fail("link not released");
  endtask
  task automatic t_flags();
    wr('{DEV, ADDR_SHUTDOWN, 8'h01}, 0);
    tests_run++;
    if (flags !== 3'b100) fail("shutdown write");
    wr('{DEV, ADDR_GLOBAL, 8'h01, 8'h01}, 0);
    tests_run++;
    if (flags !== 3'b111) fail("flags set");
  endtask
  task automatic t_stage();
    wr('{DEV, ADDR_DUTY_LAST, 8'ha5, 8'h07, 8'h01, 8'h03, 8'h05, 8'h07}, 0);
    tests_run++;
    if (channel_duty[35] !== 8'h00 || channel_on !== '0) fail("staged values early");
    wr('{DEV, ADDR_APPLY, TRIGGER_VALUE}, 0);
    tests_run++;
    if (channel_duty[35] !== 8'ha5 || channel_on[3:0] !== 4'hf) fail("apply");
    tests_run++;
    if (current_scale[3:0] !== 8'he4) fail("scale codes");
  endtask
  task automatic t_unlisted();
    wr('{DEV, 8'h4c, 8'h00, 8'h00, 8'h00}, 0);
    wr('{DEV, 8'h50, 8'h00, 8'h00}, 0);
    tests_run++;
    if (channel_duty[35] !== 8'ha5 || flags !== 3'b111) fail("unlisted write acted");
  endtask
  task automatic t_strap();
    addr_select <= 2'b01;
    wr('{DEV, ADDR_FREQ, 8'h00}, 3);
    tests_run++;
    if (frequency_choice !== 1'b1) fail("old address obeyed");
    wr('{DEV_ALT, ADDR_FREQ, 8'h00}, 0);
    tests_run++;
    if (flags !== 3'b110) fail("strap address");
    addr_select <= 2'b10;
  endtask
  task automatic t_soft();
    wr('{DEV, ADDR_SOFT_RESET, 8'h01}, 0);
    tests_run++;
    if (channel_duty[35] !== 8'ha5 || flags !== 3'b110) fail("nonzero reset acted");
    wr('{DEV, ADDR_SOFT_RESET, 8'h00}, 0);
    tests_run++;
    if (channel_duty !== '0 || channel_on !== '0) fail("channels kept");
    tests_run++;
    if (current_scale !== '0 || flags !== 3'b000) fail("soft reset");
    wr('{DEV, ADDR_APPLY, TRIGGER_VALUE}, 0);
    tests_run++;
    if (channel_duty[35] !== 8'h00 || channel_on !== '0) fail("staged kept");
    wr('{DEV | 8'h01, ADDR_SHUTDOWN, 8'h01}, 3);
    wr('{DEV ^ 8'h04}, 1);
    tests_run++;
    if (soft_shutdown_bit !== 1'b0) fail("refused frame wrote");
  endtask
  // reset held four edges so the cleared outputs settle before it lifts
  task automatic t_hard();
    wr('{DEV, ADDR_SHUTDOWN, 8'h01}, 0);
    wr('{DEV, ADDR_DUTY_FIRST, 8'h5a}, 0);
    wr('{DEV, ADDR_APPLY, TRIGGER_VALUE}, 0);
    tests_run++;
    if (channel_duty[0] !== 8'h5a || soft_shutdown_bit !== 1'b1) fail("pre reset");
    wr('{DEV, ADDR_DUTY_FIRST, 8'h33}, 0);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    wr('{DEV, ADDR_APPLY, TRIGGER_VALUE}, 0);
    tests_run++;
    if (channel_duty[0] !== 8'h00) fail("staged duty kept");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_flags();
    t_stage();
    t_unlisted();
    t_strap();
    t_soft();
    t_hard();
    test_done();
  end
endmodule
